//--- hctc_consts.vh
// constants for the host transfer counter and processor interrupt status block
`ifndef HCTC_CONSTS_VH
`define HCTC_CONSTS_VH

// command codes
`define HCTC_CMD_XFER_CNT_RD  8'h22
`define HCTC_CMD_XFER_CNT_WR  8'hA2
`define HCTC_CMD_IRQ_STAT_RD  8'h24
`define HCTC_CMD_IRQ_STAT_WR  8'hA4

// reset values
`define HCTC_XFER_CNT_RST     16'h0000
`define HCTC_IRQ_STAT_RST     16'h0000

// status field positions
`define HCTC_BIT_FRAME_ISO    0
`define HCTC_BIT_ASYNC_LIST   1
`define HCTC_BIT_XFER_DONE    2
`define HCTC_BIT_RSVD         3
`define HCTC_BIT_OPR_UPDATE   4
`define HCTC_BIT_HOST_SUSP    5
`define HCTC_BIT_CLK_READY    6
`define HCTC_IRQ_FLAGS        7

// largest counts the driver may program
`define HCTC_ACK_LIST_MAX     16'h1000
`define HCTC_ISO_LIST_MAX     16'h0800

// timing
`define HCTC_REF_CLK_MHZ      40
`define HCTC_CLK_READY_TYP_US 160
`define HCTC_CLK_READY_MAX_US 1000
// typical clock-ready wait counted in reference clock cycles
`define HCTC_CLK_READY_TYP_CYC 16'h1900

`endif

//--- hctc_sticky_flag.v
// one sticky status flag, set by hardware, cleared by a write of one
`timescale 1ns/10ps
`default_nettype none
module hctc_sticky_flag (
   input  wire ref_clk_i,
   input  wire sys_rst_i,
   input  wire set_i,
   input  wire clr_i,
   output reg  flag_o
);

   // -----------------------------------------------------------
   // flag storage
   // -----------------------------------------------------------
   // set is tested first so an event in the clearing cycle is kept
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

//--- hctc_xfer_count.v
// byte progress counter that signals when a transfer reaches its programmed length
`timescale 1ns/10ps
`default_nettype none
module hctc_xfer_count #(
   parameter W = 16
) (
   input  wire         ref_clk_i,
   input  wire         sys_rst_i,
   input  wire         start_i,
   input  wire         beat_i,
   input  wire [1:0]   beat_bytes_i,
   input  wire [W-1:0] target_i,
   input  wire         count_en_i,
   output reg          done_o,
   output reg          busy_o
);

   reg  [W:0] moved_q;
   wire [W:0] moved_nx;

   // one extra bit so the sum cannot wrap past a full 16-bit target
   assign moved_nx = moved_q + {{(W-1){1'b0}}, beat_bytes_i};

   // -----------------------------------------------------------
   // progress tracking
   // -----------------------------------------------------------
   // a zero target never ends by count; the transfer waits for an outside end
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         moved_q <= {(W+1){1'b0}};
         done_o  <= 1'b0;
         busy_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            moved_q <= {(W+1){1'b0}};
            busy_o  <= 1'b1;
         end else if (busy_o && beat_i) begin
            moved_q <= moved_nx;
            if (count_en_i && (target_i != {W{1'b0}}) &&
                (moved_nx >= {1'b0, target_i})) begin
               done_o <= 1'b1;
               busy_o <= 1'b0;
            end
         end
      end
   end

endmodule
`default_nettype wire

//--- hctc_top.v
// host transfer byte counter and processor interrupt status register
`timescale 1ns/10ps
`default_nettype none
`include "hctc_consts.vh"
module hctc_top #(
   parameter [15:0] CLK_READY_CYC = `HCTC_CLK_READY_TYP_CYC
) (
   input  wire        ref_clk_i,
   input  wire        sys_rst_i,
   // command port from the processor interface
   input  wire        cmd_valid_i,
   input  wire [7:0]  cmd_code_i,
   input  wire [15:0] cmd_wdata_i,
   output reg  [15:0] rd_data_o,
   output reg         rd_valid_o,
   // configuration bits held elsewhere in the controller
   input  wire        irq_pin_master_enable_i,
   input  wire [6:0]  host_cpu_irq_mask_i,
   input  wire        dma_count_use_i,
   // transfer progress
   input  wire        xfer_start_i,
   input  wire        xfer_is_dma_i,
   input  wire        xfer_beat_i,
   input  wire [1:0]  xfer_beat_bytes_i,
   input  wire        ext_eot_pin_i,
   // host controller events
   input  wire        wakeup_sent_i,
   input  wire        host_suspended_i,
   input  wire        opr_update_i,
   input  wire        async_list_ready_i,
   input  wire        frame_start_i,
   // results
   output reg         host_irq_pin_o,
   output reg         transfer_end_event_o,
   output reg         buffer_status_update_o,
   output reg  [15:0] dma_count_o,
   output reg         xfer_busy_o
);

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   reg  [15:0] transfer_byte_counter_q;
   reg         eot_meta_q;
   reg         eot_sync_q;
   reg         eot_prev_q;
   reg         dma_run_q;
   reg         dma_counted_q;
   reg         clk_wait_q;
   reg  [15:0] clk_wait_cnt_q;
   reg         clk_ready_evt_q;
   reg         susp_prev_q;
   reg         ext_done_q;
   wire        cnt_wr;
   wire        cnt_rd;
   wire        stat_wr;
   wire        stat_rd;
   wire        count_en;
   wire        int_done;
   wire        cnt_busy;
   wire        ext_eot_rise;
   wire        ext_end;
   wire        susp_rise;
   wire [6:0]  flag_set;
   wire [6:0]  flag_clr;
   wire [6:0]  flag_q;
   wire [15:0] status_view;
   wire [6:0]  pending;

   // -----------------------------------------------------------
   // command decode
   // -----------------------------------------------------------
   // each code is a single-cycle strobe; unknown codes are ignored
   assign cnt_rd  = cmd_valid_i && (cmd_code_i == `HCTC_CMD_XFER_CNT_RD);
   assign cnt_wr  = cmd_valid_i && (cmd_code_i == `HCTC_CMD_XFER_CNT_WR);
   assign stat_rd = cmd_valid_i && (cmd_code_i == `HCTC_CMD_IRQ_STAT_RD);
   assign stat_wr = cmd_valid_i && (cmd_code_i == `HCTC_CMD_IRQ_STAT_WR);

   // -----------------------------------------------------------
   // transfer byte counter register
   // -----------------------------------------------------------
   // the driver is trusted to stay within the list buffer sizes; the
   // counter is not clipped so a wrong value shows up as a long transfer
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         transfer_byte_counter_q <= `HCTC_XFER_CNT_RST;
      end else if (cnt_wr) begin
         transfer_byte_counter_q <= cmd_wdata_i;
      end
   end

   // -----------------------------------------------------------
   // dma counter copy
   // -----------------------------------------------------------
   // the copy is taken only at dma start so later counter writes leave
   // dma_count_o alone; the count end still follows the live counter register
   // an outside end closes the dma as well, so a following pio counts
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         dma_count_o   <= 16'h0000;
         dma_run_q     <= 1'b0;
         dma_counted_q <= 1'b0;
      end else begin
         if (xfer_start_i && xfer_is_dma_i) begin
            dma_run_q     <= 1'b1;
            dma_counted_q <= dma_count_use_i;
            if (dma_count_use_i) begin
               dma_count_o <= transfer_byte_counter_q;
            end
         end else if (xfer_start_i) begin
            dma_run_q     <= 1'b0;
            dma_counted_q <= 1'b0;
         end else if (transfer_end_event_o || ext_end) begin
            dma_run_q     <= 1'b0;
            dma_counted_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------
   // progress counting
   // -----------------------------------------------------------
   // count end is always enabled for pio; for dma only when the counter was taken
   assign count_en = xfer_start_i ? 1'b0 :
                     (!dma_run_q || dma_counted_q);

   hctc_xfer_count #(
      .W            (16)
   ) u_count (
      .ref_clk_i    (ref_clk_i),
      .sys_rst_i    (sys_rst_i),
      .start_i      (xfer_start_i),
      .beat_i       (xfer_beat_i),
      .beat_bytes_i (xfer_beat_bytes_i),
      .target_i     (transfer_byte_counter_q),
      .count_en_i   (count_en),
      .done_o       (int_done),
      .busy_o       (cnt_busy)
   );

   // -----------------------------------------------------------
   // external end of transfer
   // -----------------------------------------------------------
   // the pin is asynchronous; the edge is taken from the second stage and its delayed copy
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         eot_meta_q <= 1'b0;
         eot_sync_q <= 1'b0;
         eot_prev_q <= 1'b0;
      end else begin
         eot_meta_q <= ext_eot_pin_i;
         eot_sync_q <= eot_meta_q;
         eot_prev_q <= eot_sync_q;
      end
   end

   assign ext_eot_rise = eot_sync_q && !eot_prev_q;
   // an outside end counts only while a transfer is in flight, and once
   assign ext_end      = ext_eot_rise && cnt_busy && !ext_done_q;

   // -----------------------------------------------------------
   // external end latch
   // -----------------------------------------------------------
   // the counter has no outside-end input, so the outside end is held
   // here until the next start; without it busy would come back after a
   // cycle and a second pin pulse would set the done flag again
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ext_done_q <= 1'b0;
      end else if (xfer_start_i) begin
         ext_done_q <= 1'b0;
      end else if (ext_end) begin
         ext_done_q <= 1'b1;
      end
   end

   // -----------------------------------------------------------
   // end event and buffer status strobe
   // -----------------------------------------------------------
   // both strobes come from the registered count end, so they stand in
   // the same cycle; an outside end raises neither
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         transfer_end_event_o   <= 1'b0;
         buffer_status_update_o <= 1'b0;
         xfer_busy_o            <= 1'b0;
      end else begin
         transfer_end_event_o   <= int_done;
         buffer_status_update_o <= int_done;
         xfer_busy_o            <= cnt_busy && !ext_end && !ext_done_q;
      end
   end

   // -----------------------------------------------------------
   // clock ready wait after wakeup
   // -----------------------------------------------------------
   // a fixed typical wait is used; it stays well inside the longest
   // allowed wait, and a new wakeup restarts it
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         clk_wait_q      <= 1'b0;
         clk_wait_cnt_q  <= 16'h0000;
         clk_ready_evt_q <= 1'b0;
      end else begin
         clk_ready_evt_q <= 1'b0;
         if (wakeup_sent_i) begin
            clk_wait_q     <= 1'b1;
            clk_wait_cnt_q <= 16'h0000;
         end else if (clk_wait_q) begin
            if (clk_wait_cnt_q >= CLK_READY_CYC - 16'h0001) begin
               clk_wait_q      <= 1'b0;
               clk_ready_evt_q <= 1'b1;
            end else begin
               clk_wait_cnt_q <= clk_wait_cnt_q + 16'h0001;
            end
         end
      end
   end

   // -----------------------------------------------------------
   // suspend edge
   // -----------------------------------------------------------
   // suspend is a level from the scheduler; the flag marks its onset only
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         susp_prev_q <= 1'b0;
      end else begin
         susp_prev_q <= host_suspended_i;
      end
   end

   assign susp_rise = host_suspended_i && !susp_prev_q;

   // -----------------------------------------------------------
   // status flag events and clears
   // -----------------------------------------------------------
   // each live bit is its own sticky cell; reserved bit 3 has none
   assign flag_set[`HCTC_BIT_FRAME_ISO]  = frame_start_i;
   assign flag_set[`HCTC_BIT_ASYNC_LIST] = async_list_ready_i;
   assign flag_set[`HCTC_BIT_XFER_DONE]  = int_done || ext_end;
   assign flag_set[`HCTC_BIT_RSVD]       = 1'b0;
   assign flag_set[`HCTC_BIT_OPR_UPDATE] = opr_update_i;
   assign flag_set[`HCTC_BIT_HOST_SUSP]  = susp_rise;
   assign flag_set[`HCTC_BIT_CLK_READY]  = clk_ready_evt_q;

   // only ones written clear; a read never touches the flags
   assign flag_clr = stat_wr ? cmd_wdata_i[6:0] : 7'h00;

   genvar gi;
   generate
      for (gi = 0; gi < `HCTC_IRQ_FLAGS; gi = gi + 1) begin : g_flag
         if (gi == `HCTC_BIT_RSVD) begin : g_rsvd
            assign flag_q[gi] = 1'b0;
         end else begin : g_live
            hctc_sticky_flag u_flag (
               .ref_clk_i (ref_clk_i),
               .sys_rst_i (sys_rst_i),
               .set_i     (flag_set[gi]),
               .clr_i     (flag_clr[gi]),
               .flag_o    (flag_q[gi])
            );
         end
      end
   endgenerate

   // upper bits are reserved and read as zero
   assign status_view = {9'h000, flag_q};

   // -----------------------------------------------------------
   // read data
   // -----------------------------------------------------------
   // the last answer stays on the bus until the next read, so a slow
   // processor interface may still pick it up a few cycles late
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o  <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= cnt_rd || stat_rd;
         if (cnt_rd) begin
            rd_data_o <= transfer_byte_counter_q;
         end else if (stat_rd) begin
            rd_data_o <= status_view;
         end
      end
   end

   // -----------------------------------------------------------
   // interrupt pin
   // -----------------------------------------------------------
   // mask and master enable are used as given; they are registers of
   // the wider controller and are not held again here
   // level output, active high; masks come in zero from reset
   assign pending = flag_q & host_cpu_irq_mask_i;

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         host_irq_pin_o <= 1'b0;
      end else begin
         host_irq_pin_o <= irq_pin_master_enable_i && (|pending);
      end
   end

endmodule
`default_nettype wire

//--- hctc_checker.sv
// port-level assertions for the transfer counter and status block
`timescale 1ns/10ps
`default_nettype none
`include "hctc_consts.vh"
module hctc_checker (
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        cmd_valid_i,
   input wire logic [7:0]  cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] rd_data_o,
   input wire logic        rd_valid_o,
   input wire logic        irq_pin_master_enable_i,
   input wire logic [6:0]  host_cpu_irq_mask_i,
   input wire logic        dma_count_use_i,
   input wire logic        xfer_start_i,
   input wire logic        xfer_is_dma_i,
   input wire logic        host_irq_pin_o,
   input wire logic        transfer_end_event_o,
   input wire logic        buffer_status_update_o
);
   logic ext_only_q;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ------------------------------------------
   // helper state
   // ------------------------------------------
   // a dma start without the count-use bit may only be ended by the pin
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) ext_only_q <= 1'b0;
      else if (xfer_start_i) ext_only_q <= xfer_is_dma_i & ~dma_count_use_i;
   end
   // ------------------------------------------
   // assertions
   // ------------------------------------------
   AST_RD_ANSWER: assert property (cmd_valid_i && (cmd_code_i == `HCTC_CMD_XFER_CNT_RD
      || cmd_code_i == `HCTC_CMD_IRQ_STAT_RD) |=> rd_valid_o) else $error("read not answered");
   AST_NO_ANSWER: assert property (cmd_valid_i && cmd_code_i != `HCTC_CMD_XFER_CNT_RD
      && cmd_code_i != `HCTC_CMD_IRQ_STAT_RD |=> !rd_valid_o) else $error("stray answer");
   AST_CNT_BACK: assert property ((cmd_valid_i && cmd_code_i == `HCTC_CMD_XFER_CNT_WR)
      ##1 !cmd_valid_i ##1 (cmd_valid_i && cmd_code_i == `HCTC_CMD_XFER_CNT_RD)
      |=> rd_data_o == $past(cmd_wdata_i, 3)) else $error("counter readback wrong");
   AST_RSVD_ZERO: assert property (rd_valid_o && $past(cmd_code_i) == `HCTC_CMD_IRQ_STAT_RD
      |-> rd_data_o[15:7] == 9'h000 && !rd_data_o[3]) else $error("reserved bits set");
   AST_PIN_GATED: assert property (host_irq_pin_o |-> $past(irq_pin_master_enable_i)
      && ($past(host_cpu_irq_mask_i) & 7'h77) != 7'h00) else $error("pin without enables");
   AST_PIN_MASTER: assert property (!irq_pin_master_enable_i |=> !host_irq_pin_o)
      else $error("pin without master enable");
   AST_END_PAIR: assert property (transfer_end_event_o == buffer_status_update_o)
      else $error("end event and fill update apart");
   AST_END_PULSE: assert property (transfer_end_event_o |=> !transfer_end_event_o)
      else $error("end event longer than a cycle");
   AST_EXT_ONLY: assert property (ext_only_q |-> !transfer_end_event_o)
      else $error("count ended an uncounted dma");
   cover property (rd_valid_o && rd_data_o[2]);
   cover property (transfer_end_event_o);
   cover property (host_irq_pin_o);
endmodule
bind hctc_top hctc_checker u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
   .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .dma_count_use_i(dma_count_use_i),
   .irq_pin_master_enable_i(irq_pin_master_enable_i), .host_cpu_irq_mask_i(host_cpu_irq_mask_i),
   .xfer_start_i(xfer_start_i), .xfer_is_dma_i(xfer_is_dma_i), .host_irq_pin_o(host_irq_pin_o),
   .transfer_end_event_o(transfer_end_event_o), .buffer_status_update_o(buffer_status_update_o));
`default_nettype wire

//--- hctc_cpu_model.sv
// processor model that issues command codes to the block
`timescale 1ns/10ps
`default_nettype none
module hctc_cpu_model (
   input  wire logic        ref_clk_i,
   output var  logic        cmd_valid_o,
   output var  logic [7:0]  cmd_code_o,
   output var  logic [15:0] cmd_wdata_o
);
   // ------------------------------------------
   // command issue
   // ------------------------------------------
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 8'h00;
      cmd_wdata_o = 16'h0000;
   end
   // idle bus shows inverted values so stale data is never mistaken for valid
   task automatic cmd(input logic [7:0] code, input logic [15:0] data, input int gap);
      @(posedge ref_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o  <= code;
      cmd_wdata_o <= data;
      @(posedge ref_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= ~code;
      cmd_wdata_o <= ~data;
      repeat (gap) @(posedge ref_clk_i);
   endtask
   // count is capped at the list buffer size before a transfer
   task automatic load_count(input logic iso, input logic [15:0] n);
      cmd(8'hA2, iso ? ((n > 16'h0800) ? 16'h0800 : n) : ((n > 16'h1000) ? 16'h1000 : n), 0);
   endtask
   task automatic clear_all;
      cmd(8'hA4, 16'h00FF, 0);
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the transfer counter and status block
`timescale 1ns/10ps
`default_nettype none
`include "hctc_consts.vh"
module tb_top;
   logic        ref_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        cmd_valid, rd_valid, pin, end_ev, buf_upd, busy;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, rd_data, dma_cnt;
   logic        mstr_en = 1'b0, dma_use = 1'b0, x_start = 1'b0, x_dma = 1'b0;
   logic        beat = 1'b0, ext_eot = 1'b0;
   logic [1:0]  beat_bytes = 2'h0;
   logic [6:0]  mask = 7'h00, evt = 7'h00, exp_flags = 7'h00;
   logic [15:0] exp_q[$];
   logic [31:0] rnd;
   int          mismatches = 0, checks_done = 0, ev_cnt = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   hctc_cpu_model cpu (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_wdata_o(cmd_wdata));
   hctc_top #(.CLK_READY_CYC(16'd8)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .irq_pin_master_enable_i(mstr_en),
      .host_cpu_irq_mask_i(mask), .dma_count_use_i(dma_use), .xfer_start_i(x_start),
      .xfer_is_dma_i(x_dma), .xfer_beat_i(beat), .xfer_beat_bytes_i(beat_bytes),
      .ext_eot_pin_i(ext_eot), .wakeup_sent_i(evt[6]), .host_suspended_i(evt[5]),
      .opr_update_i(evt[4]), .async_list_ready_i(evt[1]), .frame_start_i(evt[0]),
      .host_irq_pin_o(pin), .transfer_end_event_o(end_ev), .buffer_status_update_o(buf_upd),
      .dma_count_o(dma_cnt), .xfer_busy_o(busy));
   // ------------------------------------------
   // helpers
   // ------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // the expected answer is queued first; the monitor pairs answers in order
   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      exp_q.push_back(exp);
      cpu.cmd(code, 16'h0000, $urandom_range(0, 2));
   endtask
   task automatic pulse(input int b);
      @(posedge ref_clk_i);
      evt[b] <= 1'b1;
      @(posedge ref_clk_i);
      evt[b] <= 1'b0;
      exp_flags[b] = 1'b1;
   endtask
   task automatic pin_chk(input logic m, input logic [6:0] mk);
      @(posedge ref_clk_i);
      mstr_en <= m;
      mask    <= mk;
      repeat (3) @(posedge ref_clk_i);
      check({15'h0000, pin}, {15'h0000, m & |(mk & exp_flags & 7'h77)});
   endtask
   // random beat sizes so the total may overshoot the programmed count
   task automatic xfer(input logic dma, input logic [15:0] n);
      int sum;
      logic [1:0] step;
      sum = 0;
      @(posedge ref_clk_i);
      x_start <= 1'b1;
      x_dma   <= dma;
      @(posedge ref_clk_i);
      x_start <= 1'b0;
      while (sum < n) begin
         // a local step keeps the caller's random count intact
         step = 2'($urandom_range(1, 3));
         beat       <= 1'b1;
         beat_bytes <= step;
         sum += step;
         @(posedge ref_clk_i);
      end
      beat <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask
   // ------------------------------------------
   // monitor, watchdog and main sequence
   // ------------------------------------------
   always @(posedge ref_clk_i) begin
      if (end_ev === 1'b1) ev_cnt++;
      if (rd_valid === 1'b1 && exp_q.size() > 0) check(rd_data, exp_q.pop_front());
      else if (rd_valid === 1'b1) check(16'h0001, 16'h0000);
   end
   initial begin
      #500000;
      mismatches++;
      finish_test;
   end
   initial begin
      rnd = $urandom(32'hA35C752E);
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(`HCTC_CMD_XFER_CNT_RD, 16'h0000);
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom;
         cpu.cmd(`HCTC_CMD_XFER_CNT_WR, rnd[15:0], 0);
         rd(`HCTC_CMD_XFER_CNT_RD, rnd[15:0]);
      end
      cpu.cmd(8'h23, 16'h0000, 0); // unused code stays silent
      pulse(0);
      pulse(1);
      pulse(4);
      pulse(5);
      pulse(6);
      repeat (12) @(posedge ref_clk_i);
      rd(`HCTC_CMD_IRQ_STAT_RD, {9'h000, exp_flags});
      rd(`HCTC_CMD_IRQ_STAT_RD, {9'h000, exp_flags});
      for (int b = 0; b < 7; b++) pin_chk(1'b1, 7'h01 << b);
      pin_chk(1'b0, 7'h7F);
      pin_chk(1'b1, 7'h00);
      cpu.cmd(`HCTC_CMD_IRQ_STAT_WR, 16'hFF88, 0);
      cpu.cmd(`HCTC_CMD_IRQ_STAT_WR, 16'h0000, 0);
      rd(`HCTC_CMD_IRQ_STAT_RD, {9'h000, exp_flags});
      cpu.cmd(`HCTC_CMD_IRQ_STAT_WR, 16'h0011, 0);
      exp_flags = exp_flags & ~7'h11;
      rd(`HCTC_CMD_IRQ_STAT_RD, {9'h000, exp_flags});
      fork
         cpu.cmd(`HCTC_CMD_IRQ_STAT_WR, 16'h0001, 0);
         pulse(0);
      join
      rd(`HCTC_CMD_IRQ_STAT_RD, {9'h000, exp_flags});
      cpu.clear_all;
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0000);
      rnd = $urandom_range(2, 40);
      cpu.load_count(1'b0, rnd[15:0]);
      xfer(1'b0, rnd[15:0]);
      check(ev_cnt[15:0], 16'h0001);
      check({15'h0000, busy}, 16'h0000);
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0004);
      cpu.clear_all;
      dma_use <= 1'b1;
      rnd = $urandom_range(2, 40);
      cpu.load_count(1'b1, rnd[15:0]);
      xfer(1'b1, rnd[15:0]);
      check(dma_cnt, rnd[15:0]);
      check(ev_cnt[15:0], 16'h0002);
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0004);
      cpu.clear_all;
      dma_use <= 1'b0;
      xfer(1'b1, 16'h0030);
      check(ev_cnt[15:0], 16'h0002);
      check({15'h0000, busy}, 16'h0001);
      ext_eot <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      ext_eot <= 1'b0;
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0004);
      check(ev_cnt[15:0], 16'h0002);
      check({15'h0000, busy}, 16'h0000);
      cpu.clear_all;
      ext_eot <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      ext_eot <= 1'b0;
      rd(`HCTC_CMD_IRQ_STAT_RD, 16'h0000);
      repeat (6) @(posedge ref_clk_i);
      check(16'(exp_q.size()), 16'h0000);
      finish_test;
   end
endmodule
`default_nettype wire
